/* File: design/eep_pkg.sv */
/*
 * Constants shared by the data EEPROM control block: address split, control register
 * field positions, launch command codes, reset values, timing and the sequencer states.
 * Assumes a single 25 MHz core clock.
 */
package eep_pkg;

   // ----------------------------------------------------------------
   // Address split
   // ----------------------------------------------------------------
   localparam int EEP_ADDR_W  = 11;            // Byte address width of the array
   localparam int EEP_PAGE_W  = 4;             // Upper bits select the row
   localparam int EEP_BYTE_W  = 7;             // Lower bits select byte in row
   localparam int EEP_PAGE_SZ = 128;           // Bytes in one row

   // ----------------------------------------------------------------
   // Control register layout
   // ----------------------------------------------------------------
   localparam int         EEP_BUSY_BIT   = 0;  // Busy flag position
   localparam int         EEP_SPACE_BIT  = 1;  // Space select position
   localparam int         EEP_LAUNCH_LSB = 4;  // Launch field low bit
   localparam logic [3:0] EEP_LAUNCH_ARM = 4'h5; // First launch command
   localparam logic [3:0] EEP_LAUNCH_GO  = 4'ha; // Second launch command
   localparam logic       EEP_SPACE_RST  = 1'b0; // Space select after reset
   localparam logic       EEP_BUSY_RST   = 1'b0; // Busy flag after reset
   localparam logic [7:0] EEP_BLOCK_DATA = 8'hff; // Read answer while busy

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int EEP_CLK_NS       = 40;       // Core clock period
   localparam int EEP_PROG_TIME_NS = 10000;    // Cell programming time, plain default
   localparam int EEP_PROG_CYCLES  = (EEP_PROG_TIME_NS + EEP_CLK_NS - 1) / EEP_CLK_NS;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {EEP_IDLE, EEP_WAIT, EEP_COPY} eep_state_e;

endpackage

/* File: design/eep_prog_timer.sv */
/*
 * Programming time counter: a start pulse loads the count, a one-cycle done pulse
 * marks the end. Assumes start is not repeated while a count runs.
 */
`timescale 1ns/1ns
`default_nettype none
module eep_prog_timer
#(
   parameter int CYCLES = eep_pkg::EEP_PROG_CYCLES
)
(
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic start,
   output var  logic done
);
   import eep_pkg::*;

   localparam int CW = $clog2(CYCLES + 1);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   generate
      if (CYCLES < 1)
      begin : g_bad
         $error("eep_prog_timer: CYCLES must be at least 1");
      end
   endgenerate

   logic [CW-1:0] cnt_reg;                     // Cycles still to run
   logic [CW-1:0] cnt_next;
   logic          done_next;

   // Next count and end pulse
   always_comb
   begin
      cnt_next  = cnt_reg;
      done_next = 1'b0;
      if (start)
      begin
         cnt_next = CW'(CYCLES);
      end
      else if (cnt_reg != '0)
      begin
         cnt_next  = cnt_reg - 1'b1;
         done_next = (cnt_reg == CW'(1));
      end
   end

   // Register the count
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         cnt_reg <= '0;
         done    <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         done    <= done_next;
      end
   end
endmodule
`default_nettype wire

/* File: design/eep_ctrl.sv */
/*
 * Data EEPROM control: column latches for one row, two-write launch sequence, busy
 * flag, array read, and routing of external data moves to the EEPROM or to RAM.
 * Assumes the core gives one-cycle strobes synchronous to sys_clk, and an
 * instruction-done pulse for every instruction, the control write's included.
 */
`timescale 1ns/1ns
`default_nettype none
// What this block does, and what it needs from the core
// RQ1 - Programmed row comes from the latched page
// RQ2 - First latched page kept, later pages dropped
// RQ3 - Launch only on 5x then Ax writes
// RQ4 - Busy set by hardware on launch
// RQ5 - Reads while busy return no stored data
// RQ6 - Busy cleared by hardware when row done
// RQ7 - Launch writes back to back, else abort
// RQ8 - Core fills latches bytewise within one page
// RQ9 - Core reads via space select and pointer
// RQ10 - Core masks interrupts around access sequences
// RQ11 - Space select steers moves to EEPROM/RAM
// RQ12 - Upper 4 bits row, lower 7 byte
// RQ13 - Marker per latch, only marked programmed
// RQ14 - Software writes never touch busy flag
// RQ15 - Loads and launches ignored while busy
module eep_ctrl
#(
   parameter int PROG_CYCLES = eep_pkg::EEP_PROG_CYCLES
)
(
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        instr_done,    // One pulse per finished instruction
   input  wire logic        ctl_wr,        // Control register write
   input  wire logic [7:0]  ctl_wdata,
   output var  logic [7:0]  ctl_rdata,     // Control register readback
   input  wire logic        xd_wr,         // External data move, write
   input  wire logic        xd_rd,         // External data move, read
   input  wire logic [15:0] data_pointer,  // Move address
   input  wire logic [7:0]  xd_wdata,
   output var  logic [7:0]  xd_rdata,
   output var  logic        xd_rvalid,     // EEPROM read answer
   output var  logic        rd_blocked,    // Read refused while busy
   output var  logic        xram_wr,       // Move forwarded to RAM
   output var  logic        xram_rd,
   output var  logic [15:0] xram_addr,
   output var  logic [7:0]  xram_wdata,
   output var  logic        prog_busy_flag,
   output var  logic        nv_space_select
);
   import eep_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   generate
      if (EEP_PAGE_W + EEP_BYTE_W != EEP_ADDR_W || (1 << EEP_BYTE_W) != EEP_PAGE_SZ)
      begin : g_bad
         $error("eep_ctrl: address split does not match page size");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0]            array_mem [0:(1<<EEP_ADDR_W)-1]; // Nonvolatile array model
   logic [7:0]            latch_mem [0:EEP_PAGE_SZ-1];     // Column latches
   logic [EEP_PAGE_SZ-1:0] mark_reg;                       // Written markers
   logic [EEP_PAGE_SZ-1:0] mark_next;
   logic [EEP_PAGE_W-1:0]  page_reg;                       // Latched row
   logic [EEP_PAGE_W-1:0]  page_next;

   // ----------------------------------------------------------------
   // Control and sequencer state
   // ----------------------------------------------------------------
   eep_state_e            state_reg;
   eep_state_e            state_next;
   logic                  armed_reg;           // First launch write seen
   logic                  armed_next;
   logic                  space_next;
   logic                  busy_next;
   logic                  launch;              // Valid launch this cycle
   logic                  timer_done;
   logic [EEP_BYTE_W-1:0] idx_reg;             // Copy walk position
   logic [EEP_BYTE_W-1:0] idx_next;
   logic [3:0]            cmd;                 // Launch field of the write
   logic [EEP_BYTE_W-1:0] waddr_byte;
   logic [EEP_PAGE_W-1:0] waddr_page;
   logic                  load;                // Column latch load
   logic                  nv_rd;               // EEPROM read

   assign cmd        = ctl_wdata[EEP_LAUNCH_LSB +: 4];
   assign waddr_byte = data_pointer[EEP_BYTE_W-1:0];                   // RQ12
   assign waddr_page = data_pointer[EEP_ADDR_W-1:EEP_BYTE_W];          // RQ12
   // Loads while busy are dropped so the running row stays intact
   assign load       = xd_wr && nv_space_select && !prog_busy_flag;    // RQ11 RQ15
   assign nv_rd      = xd_rd && nv_space_select;                       // RQ11

   // ----------------------------------------------------------------
   // Launch sequence and space select
   // ----------------------------------------------------------------
   // Any instruction between the two launch writes disarms the sequence
   always_comb
   begin
      space_next = nv_space_select;
      armed_next = armed_reg;
      launch     = 1'b0;
      if (ctl_wr)
      begin
         // The written busy bit is ignored: only the sequencer moves it
         space_next = ctl_wdata[EEP_SPACE_BIT];                        // RQ14
         if (prog_busy_flag)
         begin
            armed_next = 1'b0;                                         // RQ15
         end
         else if (cmd == EEP_LAUNCH_ARM)
         begin
            armed_next = 1'b1;                                         // RQ3
         end
         else if (armed_reg && cmd == EEP_LAUNCH_GO)
         begin
            launch     = 1'b1;                                         // RQ3
            armed_next = 1'b0;
         end
         else
         begin
            armed_next = 1'b0;                                         // RQ7
         end
      end
      else if (instr_done)
      begin
         armed_next = 1'b0;                                            // RQ7
      end
   end

   // ----------------------------------------------------------------
   // Programming sequencer
   // ----------------------------------------------------------------
   // Wait out the cell time, then walk the row and store marked bytes
   always_comb
   begin
      state_next = state_reg;
      idx_next   = idx_reg;
      case (state_reg)
         EEP_IDLE:
         begin
            if (launch)
            begin
               state_next = EEP_WAIT;
               idx_next   = '0;
            end
         end
         EEP_WAIT:
         begin
            if (timer_done)
            begin
               state_next = EEP_COPY;
            end
         end
         EEP_COPY:
         begin
            idx_next = idx_reg + 1'b1;
            if (idx_reg == EEP_BYTE_W'(EEP_PAGE_SZ - 1))
            begin
               state_next = EEP_IDLE;
            end
         end
         default:
         begin
            state_next = EEP_IDLE;
         end
      endcase
      busy_next = (state_next != EEP_IDLE);                            // RQ4 RQ6
   end

   // ----------------------------------------------------------------
   // Markers and page capture
   // ----------------------------------------------------------------
   // The page is taken only while no marker is set, i.e. by the first load
   always_comb
   begin
      mark_next = mark_reg;
      page_next = page_reg;
      if (load)
      begin
         mark_next[waddr_byte] = 1'b1;                                 // RQ13
         if (mark_reg == '0)
         begin
            page_next = waddr_page;                                    // RQ1 RQ2
         end
      end
      else if (state_reg == EEP_COPY && state_next == EEP_IDLE)
      begin
         mark_next = '0;                                               // RQ13
      end
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         state_reg       <= EEP_IDLE;
         idx_reg         <= '0;
         armed_reg       <= 1'b0;
         mark_reg        <= '0;
         page_reg        <= '0;
         nv_space_select <= EEP_SPACE_RST;
         prog_busy_flag  <= EEP_BUSY_RST;
      end
      else
      begin
         state_reg       <= state_next;
         idx_reg         <= idx_next;
         armed_reg       <= armed_next;
         mark_reg        <= mark_next;
         page_reg        <= page_next;
         nv_space_select <= space_next;
         prog_busy_flag  <= busy_next;
      end
   end

   // ----------------------------------------------------------------
   // Latch and array writes
   // ----------------------------------------------------------------
   // No reset: contents are data, validity is carried by the markers
   always_ff @(posedge sys_clk)
   begin
      if (load)
      begin
         latch_mem[waddr_byte] <= xd_wdata;
      end
      if (state_reg == EEP_COPY && mark_reg[idx_reg])
      begin
         array_mem[{page_reg, idx_reg}] <= latch_mem[idx_reg];         // RQ1 RQ13
      end
   end

   // ----------------------------------------------------------------
   // Read answers, RAM forwarding, readback
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         xd_rdata   <= '0;
         xd_rvalid  <= 1'b0;
         rd_blocked <= 1'b0;
         xram_wr    <= 1'b0;
         xram_rd    <= 1'b0;
         xram_addr  <= '0;
         xram_wdata <= '0;
         ctl_rdata  <= '0;
      end
      else
      begin
         xd_rvalid  <= nv_rd;
         rd_blocked <= nv_rd && prog_busy_flag;                        // RQ5
         if (nv_rd)
         begin
            xd_rdata <= prog_busy_flag ? EEP_BLOCK_DATA                // RQ5
                        : array_mem[data_pointer[EEP_ADDR_W-1:0]];
         end
         xram_wr    <= xd_wr && !nv_space_select;                      // RQ11
         xram_rd    <= xd_rd && !nv_space_select;                      // RQ11
         xram_addr  <= data_pointer;
         xram_wdata <= xd_wdata;
         // Launch field and reserved bits read as zero
         ctl_rdata  <= {6'h00, space_next, busy_next};
      end
   end

   // ----------------------------------------------------------------
   // Programming time
   // ----------------------------------------------------------------
   eep_prog_timer #(
      .CYCLES (PROG_CYCLES)
   ) u_timer (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .start   (launch),
      .done    (timer_done)
   );
endmodule
`default_nettype wire

/* File: sim/eep_ctrl_checker.sv */
/* Port checker for eep_ctrl: read answers, move routing, launch and busy timing.
   Assumes it is bound to eep_ctrl and sees only that module's ports. */
`timescale 1ns/1ns
`default_nettype none
module eep_ctrl_checker
#(
   parameter int PROG_CYCLES = 3
)
(
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        instr_done,
   input wire logic        ctl_wr,
   input wire logic [7:0]  ctl_wdata,
   input wire logic [7:0]  ctl_rdata,
   input wire logic        xd_wr,
   input wire logic        xd_rd,
   input wire logic [15:0] data_pointer,
   input wire logic [7:0]  xd_wdata,
   input wire logic [7:0]  xd_rdata,
   input wire logic        xd_rvalid,
   input wire logic        rd_blocked,
   input wire logic        xram_wr,
   input wire logic        xram_rd,
   input wire logic [15:0] xram_addr,
   input wire logic [7:0]  xram_wdata,
   input wire logic        prog_busy_flag,
   input wire logic        nv_space_select
);
   import eep_pkg::*;
   // -----------------------------
   // Busy length counter
   // -----------------------------
   localparam int BUSY_MAX = PROG_CYCLES + 140; // Wait plus row copy, with slack
   int unsigned   busy_cnt;                     // Cycles of the running busy spell
   // Restarts at every idle cycle so only one spell is ever measured
   always_ff @(posedge sys_clk)
      busy_cnt <= (!nrst || !prog_busy_flag) ? 0 : busy_cnt + 1;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // -----------------------------
   // Properties
   // -----------------------------
   property p_rd_answer; xd_rd && nv_space_select |=> xd_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("array read not answered");
   property p_blocked; xd_rd && nv_space_select && prog_busy_flag |=> rd_blocked && xd_rdata == EEP_BLOCK_DATA;
   endproperty
   a_blocked: assert property (p_blocked) else $error("read during busy gave data");
   property p_ram_wr;
      xd_wr && !nv_space_select |=> xram_wr && xram_addr == $past(data_pointer) && xram_wdata == $past(xd_wdata);
   endproperty
   a_ram_wr: assert property (p_ram_wr) else $error("ram write not forwarded");
   property p_ee_wr; xd_wr && nv_space_select |=> !xram_wr; endproperty
   a_ee_wr: assert property (p_ee_wr) else $error("latch load leaked to ram");
   property p_launch;
      (ctl_wr && ctl_wdata[7:4] == EEP_LAUNCH_ARM && !prog_busy_flag) ##1 (ctl_wr && ctl_wdata[7:4] == EEP_LAUNCH_GO)
      |=> prog_busy_flag;
   endproperty
   a_launch: assert property (p_launch) else $error("launch did not raise busy");
   property p_rose_cause;
      $rose(prog_busy_flag) |-> $past(ctl_wr) && $past(ctl_wdata[7:4]) == EEP_LAUNCH_GO && $past(ctl_wr, 2)
      && $past(ctl_wdata[7:4], 2) == EEP_LAUNCH_ARM;
   endproperty
   a_rose_cause: assert property (p_rose_cause) else $error("busy rose without back to back launch");
   property p_busy_min; $rose(prog_busy_flag) |-> prog_busy_flag [*8]; endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy dropped early");
   property p_busy_max; busy_cnt <= BUSY_MAX; endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy never cleared");
   property p_readback; ctl_rdata == {6'h00, nv_space_select, prog_busy_flag}; endproperty
   a_readback: assert property (p_readback) else $error("control readback wrong");
   property p_space; ctl_wr |=> nv_space_select == $past(ctl_wdata[EEP_SPACE_BIT]); endproperty
   a_space: assert property (p_space) else $error("space select not taken");
   c_launch: cover property (p_launch);
   c_blocked: cover property (xd_rd && nv_space_select && prog_busy_flag);
   c_ram: cover property (xd_wr && !nv_space_select);
endmodule
bind eep_ctrl eep_ctrl_checker #(.PROG_CYCLES(PROG_CYCLES)) eep_ctrl_checker_i (
   .sys_clk(sys_clk), .nrst(nrst), .instr_done(instr_done), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
   .ctl_rdata(ctl_rdata), .xd_wr(xd_wr), .xd_rd(xd_rd), .data_pointer(data_pointer), .xd_wdata(xd_wdata),
   .xd_rdata(xd_rdata), .xd_rvalid(xd_rvalid), .rd_blocked(rd_blocked), .xram_wr(xram_wr), .xram_rd(xram_rd),
   .xram_addr(xram_addr), .xram_wdata(xram_wdata), .prog_busy_flag(prog_busy_flag),
   .nv_space_select(nv_space_select));
`default_nettype wire

/* File: sim/eep_core_model.sv */
/* Processor core model: control writes, external data moves, launch sequences.
   Assumes one instruction per step, driven on the falling edge of sys_clk. */
`timescale 1ns/1ns
`default_nettype none
module eep_core_model
(
   input  wire logic        sys_clk,
   input  wire logic        xd_rvalid,
   input  wire logic        rd_blocked,
   input  wire logic [7:0]  xd_rdata,
   output var  logic        instr_done,
   output var  logic        ctl_wr,
   output var  logic [7:0]  ctl_wdata,
   output var  logic        xd_wr,
   output var  logic        xd_rd,
   output var  logic [15:0] data_pointer,
   output var  logic [7:0]  xd_wdata
);
   // Strobes idle at time zero; address and data stay unknown until the first
   // instruction; the block copies them to xram_addr and xram_wdata every cycle but acts on them only with a strobe
   initial {instr_done, ctl_wr, xd_wr, xd_rd} = 4'h0;
   // One instruction; no interrupt can slip between steps of a sequence
   task automatic step(input logic c, w, r, input logic [7:0] cd, input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      {instr_done, ctl_wr, xd_wr, xd_rd} = {1'b1, c, w, r};
      {ctl_wdata, data_pointer, xd_wdata} = {cd, a, d};
   endtask
   // Released lines show the inverse so stale values are never mistaken for valid
   task automatic idle;
      @(negedge sys_clk);
      {instr_done, ctl_wr, xd_wr, xd_rd} = 4'h0;
      {ctl_wdata, data_pointer, xd_wdata} = ~{ctl_wdata, data_pointer, xd_wdata};
   endtask
   task automatic ctl_write(input logic [7:0] v);
      step(1'b1, 1'b0, 1'b0, v, 16'h0000, 8'h00);
      idle();
   endtask
   // Bytewise latch load, repeatable up to a full row
   task automatic xd_write(input logic [15:0] a, input logic [7:0] d);
      step(1'b0, 1'b1, 1'b0, 8'h00, a, d);
      idle();
   endtask
   // Pointer and read strobe, answer taken the cycle after
   task automatic xd_read(input logic [15:0] a, output logic [7:0] d, output logic v, b);
      step(1'b0, 1'b0, 1'b1, 8'h00, a, 8'h00);
      idle();
      {d, v, b} = {xd_rdata, xd_rvalid, rd_blocked};
   endtask
   // 5x then Ax back to back; gap puts another instruction between
   task automatic launch(input logic gap);
      step(1'b1, 1'b0, 1'b0, 8'h52, 16'h0000, 8'h00);
      if (gap)
         step(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000, 8'h00);
      step(1'b1, 1'b0, 1'b0, 8'ha2, 16'h0000, 8'h00);
      idle();
   endtask
endmodule
`default_nettype wire

/* File: sim/eeprom_page_write_read_control_tb.sv */
/* Self-checking bench for eep_ctrl driven through the core model.
   Assumes a short programming count so each row keeps busy set for 132 cycles. */
`timescale 1ns/1ns
`default_nettype none
module eeprom_page_write_read_control_tb;
   import eep_pkg::*;
   localparam int PROG = 3;                     // Shortened programming wait
   logic sys_clk, nrst, instr_done, ctl_wr, xd_wr, xd_rd, xd_rvalid, rd_blocked, xram_wr, xram_rd;
   logic prog_busy_flag, nv_space_select, ok, blk;
   logic [7:0] ctl_wdata, ctl_rdata, xd_wdata, xd_rdata, xram_wdata, rd;
   logic [15:0] data_pointer, xram_addr;
   int bad_count = 0, n_checks = 0, cyc = 0, n;
   eep_ctrl #(.PROG_CYCLES(PROG)) eep_ctrl_i (.sys_clk(sys_clk), .nrst(nrst), .instr_done(instr_done),
      .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .xd_wr(xd_wr), .xd_rd(xd_rd),
      .data_pointer(data_pointer), .xd_wdata(xd_wdata), .xd_rdata(xd_rdata), .xd_rvalid(xd_rvalid),
      .rd_blocked(rd_blocked), .xram_wr(xram_wr), .xram_rd(xram_rd), .xram_addr(xram_addr),
      .xram_wdata(xram_wdata), .prog_busy_flag(prog_busy_flag), .nv_space_select(nv_space_select));
   eep_core_model eep_core_model_i (.sys_clk(sys_clk), .xd_rvalid(xd_rvalid), .rd_blocked(rd_blocked),
      .xd_rdata(xd_rdata), .instr_done(instr_done), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .xd_wr(xd_wr),
      .xd_rd(xd_rd), .data_pointer(data_pointer), .xd_wdata(xd_wdata));
   initial
   begin
      sys_clk = 0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Hang guard: the whole run needs well under this many cycles
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         bad_count++;
         conclude();
      end
   end
   task automatic check(input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Array read with data, answer and refusal flag compared
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] d, input logic b);
      eep_core_model_i.xd_read(a, rd, ok, blk);
      check(rd, d);
      check(ok, 1'b1);
      check(blk, b);
   endtask
   // Bounded wait for the row to finish
   task automatic wait_idle;
      n = 0;
      while (prog_busy_flag === 1'b1 && n < PROG + 140)
      begin
         @(negedge sys_clk);
         n++;
      end
      check(prog_busy_flag, 1'b0);
   endtask
   initial
   begin
      nrst = 0;
      repeat (5) @(negedge sys_clk);
      nrst = 1;
      check(ctl_rdata, 8'h00);
      eep_core_model_i.xd_write(16'h1234, 8'ha5);
      check({xram_wr, xram_wdata}, 9'h1a5);
      check(xram_addr, 16'h1234);
      eep_core_model_i.xd_read(16'h0042, rd, ok, blk);
      check({xram_rd, ok}, 2'b10);
      eep_core_model_i.ctl_write(8'h03);
      check(ctl_rdata, 8'h02);
      eep_core_model_i.xd_write(16'h0085, 8'h3c);
      check(xram_wr, 1'b0);
      eep_core_model_i.xd_write(16'h0086, 8'hc3);
      eep_core_model_i.xd_write(16'h0108, 8'h5a);
      eep_core_model_i.launch(1'b0);
      check(prog_busy_flag, 1'b1);
      rd_chk(16'h0085, EEP_BLOCK_DATA, 1'b1);
      eep_core_model_i.xd_write(16'h0085, 8'h00);
      eep_core_model_i.launch(1'b0);
      eep_core_model_i.ctl_write(8'h03);
      check(ctl_rdata, 8'h03);
      wait_idle();
      rd_chk(16'h0085, 8'h3c, 1'b0);
      rd_chk(16'h0086, 8'hc3, 1'b0);
      rd_chk(16'h0088, 8'h5a, 1'b0);
      eep_core_model_i.xd_write(16'h0085, 8'h11);
      eep_core_model_i.launch(1'b1);
      repeat (3) @(negedge sys_clk);
      check(prog_busy_flag, 1'b0);
      eep_core_model_i.launch(1'b0);
      check(prog_busy_flag, 1'b1);
      wait_idle();
      rd_chk(16'h0085, 8'h11, 1'b0);
      rd_chk(16'h0086, 8'hc3, 1'b0);
      eep_core_model_i.ctl_write(8'h00);
      check(nv_space_select, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
